// *** rtl/bis_pkg.sv ***
// Purpose: constants and types for the boot and interrupt status bank
// Assumes: 16-bit register address, 8-bit data, sys_clk at 125 MHz
// Notes:   reserved bits read as zero
// Function
// - The summary bit is 1 and irq_pin_n is low while any enabled status bit is set, else 0 and released.
// - The load failed flag sets when the configuration memory read fails and stays set until reset.
// - The load done flag sets when the configuration memory read cycle completes and clears only by reset.
// - The active-low crc ok bit reads 0 after a detected memory fails its crc check, and 1 otherwise.
// - After a crc failure the serial programming port is locked until a reset through rst or reset_pin_n.
package bis_pkg;
   localparam logic [15:0] BIS_ADDR_INT_SUMMARY = 16'h021A;
   localparam logic [15:0] BIS_ADDR_EEP_FAIL    = 16'h021E;
   localparam logic [15:0] BIS_ADDR_EEP_LOAD    = 16'h021F;
   localparam int          BIS_BIT_INT          = 0;
   localparam int          BIS_BIT_FAIL         = 0;
   localparam int          BIS_BIT_DONE         = 0;
   localparam int          BIS_BIT_CRC_OK       = 3;
   localparam logic        BIS_RST_FAIL         = 1'b0;
   localparam logic        BIS_RST_DONE         = 1'b0;
   localparam logic        BIS_RST_CRC_OK       = 1'b1;
   localparam logic        BIS_RST_INT          = 1'b0;
   localparam logic        BIS_RST_IRQN         = 1'b1;
   localparam logic        BIS_RST_LOCK         = 1'b0;
   localparam logic [7:0]  BIS_RST_RDATA        = 8'h00;
   localparam int          BIS_NUM_SRC          = 8;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } bis_bus_req_t;

   // events reported by the configuration load sequencer, one-cycle pulses
   typedef struct packed {
      logic read_fail;
      logic read_done;
      logic crc_fail;
   } bis_load_evt_t;
endpackage

// *** rtl/bis_status.sv ***
// Purpose: interrupt summary and boot load status bank
// Assumes: all inputs synchronous to sys_clk; reset_pin_n already synced
// Notes:   writes are accepted and ignored, all fields are read only
`timescale 1ns/1ps
module bis_status (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   reset_pin_n,
   input  wire bis_pkg::bis_bus_req_t  bus_req,
   output logic [7:0]                  rd_data,
   input  wire logic [7:0]             irq_status,
   input  wire logic [7:0]             irq_enable,
   input  wire bis_pkg::bis_load_evt_t load_evt,
   output logic                        irq_pin_n,
   output logic                        serial_port_lock
);

   // three read only registers behind a plain strobe port. the summary
   // bit and the pin follow the enabled sources with one cycle of
   // latency; the boot flags are set by events from the load sequencer
   // and cleared only by reset; a crc failure locks the serial port
   // until rst or the reset pin is asserted. limitation: the sources are taken
   // as clean levels, so a one cycle glitch on an enabled source shows
   // on the pin for one cycle

   // state that the interrupt pin follows
   logic                            int_reg;
   logic                            int_next;
   logic                            irqn_reg;
   logic                            irqn_next;

   // sticky results of the boot time load
   logic                            fail_reg;
   logic                            fail_next;
   logic                            done_reg;
   logic                            done_next;
   logic                            crc_reg;
   logic                            crc_next;

   // serial port lock, one-hot so an upset code is easy to spot
   typedef enum logic [1:0] {
      BIS_PORT_OPEN   = 2'b01,
      BIS_PORT_LOCKED = 2'b10
   } bis_port_state_t;
   bis_port_state_t                 port_reg;
   bis_port_state_t                 port_next;
   logic                            lock_reg;
   logic                            lock_next;

   // register images and read path
   logic [7:0]                      int_image;
   logic [7:0]                      fail_image;
   logic [7:0]                      load_image;
   logic                            sel_int;
   logic                            sel_fail;
   logic                            sel_load;
   logic [7:0]                      rd_reg;
   logic [7:0]                      rd_next;

   // shared
   logic                            dev_reset;
   logic [bis_pkg::BIS_NUM_SRC-1:0] src_hit;
   logic                            any_src;

   // both reset sources clear the same state; rst and the pin are the only
   // ways out of a crc lock, so nothing else may gate them
   assign dev_reset = rst | ~reset_pin_n;

   // one and gate per source; a source whose enable is low never reaches
   // the pin, however long its status stays set
   genvar i;
   generate
      for (i = 0; i < bis_pkg::BIS_NUM_SRC; i++) begin : g_src
         assign src_hit[i] = irq_status[i] & irq_enable[i];
      end
   endgenerate

   assign any_src = |src_hit;

   // no hold term: bit and pin are recomputed every cycle, so the pin
   // lets go one cycle after the last enabled source drops
   always_comb begin
      int_next  = 1'b0;
      irqn_next = 1'b1;
      if (any_src) begin
         int_next  = 1'b1;
         irqn_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (dev_reset) begin
         int_reg  <= bis_pkg::BIS_RST_INT;
         irqn_reg <= bis_pkg::BIS_RST_IRQN;
      end else begin
         int_reg  <= int_next;
         irqn_reg <= irqn_next;
      end
   end

   // the flags are only ever set by events; the reset branches are the
   // one place that clears them, so no event can be lost to a clear
   always_comb begin
      fail_next = fail_reg;
      if (load_evt.read_fail) begin
         fail_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (dev_reset) begin
         fail_reg <= bis_pkg::BIS_RST_FAIL;
      end else begin
         fail_reg <= fail_next;
      end
   end

   always_comb begin
      done_next = done_reg;
      if (load_evt.read_done) begin
         done_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (dev_reset) begin
         done_reg <= bis_pkg::BIS_RST_DONE;
      end else begin
         done_reg <= done_next;
      end
   end

   // the crc bit reads 1 while healthy and drops to 0 on a failure
   always_comb begin
      crc_next = crc_reg;
      if (load_evt.crc_fail) begin
         crc_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (dev_reset) begin
         crc_reg <= bis_pkg::BIS_RST_CRC_OK;
      end else begin
         crc_reg <= crc_next;
      end
   end

   // once locked the port stays locked; an illegal code also locks, as
   // an open port after an upset would be the worse failure
   always_comb begin
      port_next = port_reg;
      case (port_reg)
         BIS_PORT_OPEN: begin
            if (load_evt.crc_fail) begin
               port_next = BIS_PORT_LOCKED;
            end
         end
         BIS_PORT_LOCKED: begin
            port_next = BIS_PORT_LOCKED;
         end
         default: begin
            port_next = BIS_PORT_LOCKED;
         end
      endcase
      lock_next = (port_next == BIS_PORT_LOCKED);
   end

   always_ff @(posedge sys_clk) begin
      if (dev_reset) begin
         port_reg <= BIS_PORT_OPEN;
         lock_reg <= bis_pkg::BIS_RST_LOCK;
      end else begin
         port_reg <= port_next;
         lock_reg <= lock_next;
      end
   end

   // register images; reserved positions are tied to zero so a read
   // never shows stale or undefined state
   always_comb begin
      int_image  = 8'h00;
      fail_image = 8'h00;
      load_image = 8'h00;
      int_image[bis_pkg::BIS_BIT_INT]     = int_reg;
      fail_image[bis_pkg::BIS_BIT_FAIL]   = fail_reg;
      load_image[bis_pkg::BIS_BIT_DONE]   = done_reg;
      load_image[bis_pkg::BIS_BIT_CRC_OK] = crc_reg;
   end

   // writes are not decoded at all: every field is read only, and a
   // write, reserved bits included, leaves the bank as it was
   always_comb begin
      sel_int  = 1'b0;
      sel_fail = 1'b0;
      sel_load = 1'b0;
      if (bus_req.rd) begin
         sel_int  = (bus_req.addr == bis_pkg::BIS_ADDR_INT_SUMMARY);
         sel_fail = (bus_req.addr == bis_pkg::BIS_ADDR_EEP_FAIL);
         sel_load = (bus_req.addr == bis_pkg::BIS_ADDR_EEP_LOAD);
      end
   end

   // read data stands for exactly the one cycle after the strobe and
   // is zero otherwise, so a stale value can never be taken twice
   always_comb begin
      rd_next = bis_pkg::BIS_RST_RDATA;
      case ({sel_load, sel_fail, sel_int})
         3'b001: begin
            rd_next = int_image;
         end
         3'b010: begin
            rd_next = fail_image;
         end
         3'b100: begin
            rd_next = load_image;
         end
         default: begin
            rd_next = bis_pkg::BIS_RST_RDATA;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (dev_reset) begin
         rd_reg <= bis_pkg::BIS_RST_RDATA;
      end else begin
         rd_reg <= rd_next;
      end
   end

   // every output is a flop, nothing combinational reaches a pin
   assign rd_data          = rd_reg;
   assign irq_pin_n        = irqn_reg;
   assign serial_port_lock = lock_reg;
endmodule

// *** test/bis_status_assertions.sv ***
// Purpose: concurrent checks on the status bank's ports
// Assumes: bound into bis_status and sees only its ports
// Notes:   every check pauses while either reset source is active
`timescale 1ns/1ps
module bis_chk (
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   reset_pin_n,
   input wire bis_pkg::bis_bus_req_t  bus_req,
   input wire logic [7:0]             rd_data,
   input wire logic [7:0]             irq_status,
   input wire logic [7:0]             irq_enable,
   input wire bis_pkg::bis_load_evt_t load_evt,
   input wire logic                   irq_pin_n,
   input wire logic                   serial_port_lock
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst || !reset_pin_n);

   property p_on;
      |(irq_status & irq_enable) |=> !irq_pin_n;
   endproperty
   a_on: assert property (p_on) else $error("irq pin not low");

   property p_off;
      !(|(irq_status & irq_enable)) |=> irq_pin_n;
   endproperty
   a_off: assert property (p_off) else $error("irq pin not released");

   property p_lock;
      load_evt.crc_fail |=> serial_port_lock[*2];
   endproperty
   a_lock: assert property (p_lock) else $error("port not locked");

   property p_lock_hold;
      serial_port_lock |=> serial_port_lock;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock lost");

   property p_rd_idle;
      !bus_req.rd |=> rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data stale");

   // only bit 3 and bit 0 carry fields in any register of the bank
   property p_rd_rsvd;
      bus_req.rd |=> (rd_data & 8'hF6) == 8'h00;
   endproperty
   a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bit set");

   property p_rd_int;
      bus_req.rd && bus_req.addr == bis_pkg::BIS_ADDR_INT_SUMMARY
      |=> rd_data[bis_pkg::BIS_BIT_INT] == !$past(irq_pin_n);
   endproperty
   a_rd_int: assert property (p_rd_int) else $error("summary mismatch");

   property p_fail;
      load_evt.read_fail ##[1:4]
      (bus_req.rd && bus_req.addr == bis_pkg::BIS_ADDR_EEP_FAIL)
      |=> rd_data[bis_pkg::BIS_BIT_FAIL];
   endproperty
   a_fail: assert property (p_fail) else $error("fail flag clear");

   property p_done;
      load_evt.read_done ##[1:4]
      (bus_req.rd && bus_req.addr == bis_pkg::BIS_ADDR_EEP_LOAD)
      |=> rd_data[bis_pkg::BIS_BIT_DONE];
   endproperty
   a_done: assert property (p_done) else $error("done flag clear");

   property p_crc;
      load_evt.crc_fail ##[1:4]
      (bus_req.rd && bus_req.addr == bis_pkg::BIS_ADDR_EEP_LOAD)
      |=> !rd_data[bis_pkg::BIS_BIT_CRC_OK];
   endproperty
   a_crc: assert property (p_crc) else $error("crc bit still high");
endmodule

// *** test/bis_load_model.sv ***
// Purpose: far side model of the configuration load sequencer
// Assumes: kind bit 2 is a read failure, bit 1 a finished read cycle,
//          bit 0 a crc failure; the bench holds each for one cycle
// Notes:   events pass as plain levels; the bank's flags are sticky
`timescale 1ns/1ps
module bis_load_model (
   input  wire logic [2:0]        kind,
   output bis_pkg::bis_load_evt_t evt
);
   assign evt = bis_pkg::bis_load_evt_t'(kind);
endmodule

// *** test/boot_interrupt_status_tb.sv ***
// Purpose: bench for the boot and interrupt status bank
// Assumes: load events come from bis_load_model, one cycle each
// Notes:   stimulus moves by non-blocking assignment on sys_clk
`timescale 1ns/1ps
module boot_interrupt_status_tb;
   logic                   sys_clk    = 1'b0;
   logic                   rst        = 1'b1;
   logic                   rpn        = 1'b1;
   logic [2:0]             kind       = 3'h0;
   logic [7:0]             st         = 8'h00;
   logic [7:0]             en         = 8'h00;
   logic [7:0]             q;
   logic                   pin_n;
   logic                   lock;
   int                     n_mismatch = 0;
   int                     tests_run  = 0;
   bis_pkg::bis_bus_req_t  req        = '0;
   bis_pkg::bis_load_evt_t evt;

   always #4 sys_clk = ~sys_clk;

   bis_status dut (
      .sys_clk          (sys_clk),
      .rst              (rst),
      .reset_pin_n      (rpn),
      .bus_req          (req),
      .rd_data          (q),
      .irq_status       (st),
      .irq_enable       (en),
      .load_evt         (evt),
      .irq_pin_n        (pin_n),
      .serial_port_lock (lock)
   );

   bis_load_model lm (
      .kind (kind),
      .evt  (evt)
   );

   task automatic chk(input string name, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask

   // data stands only in the cycle after the strobe, so look there
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      chk("rd_data", e, q);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   task automatic pins(input logic e_pin_n, input logic e_lock);
      @(posedge sys_clk);
      #1;
      chk("irq_pin_n", {7'h00, e_pin_n}, {7'h00, pin_n});
      chk("serial_port_lock", {7'h00, e_lock}, {7'h00, lock});
   endtask

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // the scenario takes under 150 cycles; 2000 only trips on a hang
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_mismatch++;
      complete_run;
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      pins(1'b1, 1'b0);
      rd(16'h021A, 8'h00);
      rd(16'h021E, 8'h00);
      rd(16'h021F, 8'h08);
      rd(16'h0219, 8'h00);
      @(posedge sys_clk);
      st <= 8'h90;
      en <= 8'h0F;
      pins(1'b1, 1'b0);
      @(posedge sys_clk);
      en <= 8'h30;
      pins(1'b0, 1'b0);
      rd(16'h021A, 8'h01);
      @(posedge sys_clk);
      en <= 8'h00;
      pins(1'b1, 1'b0);
      rd(16'h021A, 8'h00);
      wr(16'h021F, 8'h00);
      wr(16'h021A, 8'h00);
      rd(16'h021F, 8'h08);
      @(posedge sys_clk);
      kind <= 3'h2;
      @(posedge sys_clk);
      kind <= 3'h0;
      rd(16'h021F, 8'h09);
      rd(16'h021F, 8'h09);
      @(posedge sys_clk);
      kind <= 3'h4;
      @(posedge sys_clk);
      kind <= 3'h0;
      rd(16'h021E, 8'h01);
      rd(16'h021E, 8'h01);
      @(posedge sys_clk);
      kind <= 3'h1;
      @(posedge sys_clk);
      kind <= 3'h0;
      rd(16'h021F, 8'h01);
      pins(1'b1, 1'b1);
      @(posedge sys_clk);
      rpn <= 1'b0;
      @(posedge sys_clk);
      rpn <= 1'b1;
      pins(1'b1, 1'b0);
      rd(16'h021F, 8'h08);
      rd(16'h021E, 8'h00);
      complete_run;
   end
endmodule

bind bis_status bis_chk u_chk (.*);
